// ===== design/clock_gen_pkg.sv
// constants, field layout, reset values and types of the clock generator control
// -----------------------------------------------------------------------------
// Notes on behaviour
// - crystal runs only while oscillator enable asserted
// - crystal at crystal rate, buffered copy is reference
// - base clock is crystal or vco halved
// - reference divided by R gives divided reference; R of 0 or 1 gives the reference halved
// - feedback is vco over N times 2^P; N of 0 or 1 gives vco over 2^(P+1)
// - vco centre equals 38.4 kHz times L times 2^E
// - phase detector pulses show phase difference direction
// - lock detector compares frequencies at divided reference rate
// - tracking select reads clear in acquisition
// - tracking when not acquiring or select set
// - self-control lets lock detector pick filter mode
// - self-control tracking select read-only with hysteresis
// - self-control settled flag read-only with hysteresis
// - settled toggle requests interrupt when enabled
// - manual mode tracking select is writable control
// - manual mode disables settled flag and interrupts
// - source change holds output three edges each; a stopped source is not awaited
// - vco not selectable while loop is off
// - loop cannot power off while vco selected
// - linear factor zero disables loop, forces crystal
// -----------------------------------------------------------------------------
package clock_gen_pkg;
   // register byte offsets
   localparam logic [4:0] CTRL_OFS = 5'h00;
   localparam logic [4:0] BW_OFS = 5'h04;
   localparam logic [4:0] NDIV_OFS = 5'h08;
   localparam logic [4:0] LIN_OFS = 5'h0c;
   localparam logic [4:0] RDIV_OFS = 5'h10;
   // loop_control_reg fields
   localparam int CTRL_PWR_BIT = 0;
   localparam int CTRL_SEL_BIT = 1;
   localparam int CTRL_IE_BIT = 2;
   localparam int CTRL_P_LSB = 4;
   localparam int CTRL_E_LSB = 8;
   localparam int P_W = 2;
   localparam int E_W = 2;
   // bandwidth register fields
   localparam int BW_AUTO_BIT = 0;
   localparam int BW_TRK_BIT = 1;
   localparam int BW_SETTLED_BIT = 2;
   // reset values
   localparam logic AUTO_RST = 1'b1;
   localparam logic [P_W-1:0] P_RST = 2'h0;
   localparam logic [E_W-1:0] E_RST = 2'h0;
   localparam logic [15:0] NDIV_RST = 16'h0001;
   localparam logic [15:0] LIN_RST = 16'h0000;
   localparam logic [15:0] RDIV_RST = 16'h0001;
   // edges of each source waited on a base source change
   localparam logic [1:0] SETTLE_EDGES = 2'h3;
   // detector tolerances, in system clock cycles of period difference
   localparam logic [15:0] TRK_TOL = 16'h0004;
   localparam logic [15:0] UNT_TOL = 16'h0008;
   localparam logic [15:0] LOCK_TOL = 16'h0002;
   localparam logic [15:0] UNL_TOL = 16'h0004;
   // nominal centre frequency, 38.4 kHz in Hz
   localparam logic [31:0] F_NOM_HZ = 32'h0000_9600;
   typedef enum {SRC_RUN, SRC_HOLD} src_state_t;
endpackage

// ===== design/div_if.sv
// carrier between the control logic and one modulo divider
interface div_if #(parameter int W = 12);
   logic [W-1:0] factor;
   logic edge_in;
   logic tick;
   logic clk_out;
   modport ctl (output factor, output edge_in, input tick, input clk_out);
   modport div (input factor, input edge_in, output tick, output clk_out);
endinterface

// ===== design/modulo_divider.sv
// modulo divider of an edge stream; a factor of zero acts as one
module modulo_divider #(parameter int W = 12) (
   input wire logic clk_i,
   input wire logic rst_i,
   div_if.div d
);
   logic [W-1:0] cnt, next_cnt, last;
   logic tick, next_tick, out, next_out;

   if (W < 1 || W > 16 || $bits(d.factor) != W) begin : g_bad_w
      $error("modulo_divider: width out of range");
   end

   always_comb begin
      last = (d.factor == '0) ? '0 : d.factor - W'(1);
      next_cnt = cnt;
      next_tick = 1'b0;
      next_out = out;
      if (d.edge_in) begin
         if (cnt >= last) begin
            next_cnt = '0;
            next_tick = 1'b1;
         end else begin
            next_cnt = cnt + W'(1);
         end
         // factor one has no room for a duty cycle: toggle instead
         next_out = (last == '0) ? ~out : (next_cnt <= (last >> 1));
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt <= '0;
         tick <= 1'b0;
         out <= 1'b0;
      end else begin
         cnt <= next_cnt;
         tick <= next_tick;
         out <= next_out;
      end
   end

   assign d.tick = tick;
   assign d.clk_out = out;
endmodule

// ===== design/clock_generator.sv
// clock generator control: registers, loop dividers, detectors, base clock selector
//
// Our own choices: the placing of the registers and the Wishbone slave port.
module clock_generator #(
   parameter int N_W = 12,
   parameter int L_W = 8,
   parameter int R_W = 4,
   parameter logic [15:0] TRK_TOL = clock_gen_pkg::TRK_TOL,
   parameter logic [15:0] UNT_TOL = clock_gen_pkg::UNT_TOL,
   parameter logic [15:0] LOCK_TOL = clock_gen_pkg::LOCK_TOL,
   parameter logic [15:0] UNL_TOL = clock_gen_pkg::UNL_TOL
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [4:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic oscillator_enable_in_i,
   input wire logic xtal_pin_i,
   input wire logic vco_pin_i,
   output logic osc_run_o,
   output logic crystal_clock_o,
   output logic loop_reference_clock_o,
   output logic divided_reference_clock_o,
   output logic vco_feedback_clock_o,
   output logic base_clock_out_o,
   output logic loop_enable_o,
   output logic filter_tracking_o,
   output logic phase_up_o,
   output logic phase_down_o,
   output logic [31:0] vco_centre_hz_o,
   output logic settle_irq_o
);
   localparam int P_W = clock_gen_pkg::P_W;
   localparam int E_W = clock_gen_pkg::E_W;

   if (N_W < 1 || N_W > 16 || R_W < 1 || R_W > 16 || L_W < 1 || L_W > 12 ||
       UNT_TOL < TRK_TOL || UNL_TOL < LOCK_TOL) begin : g_bad_param
      $error("clock_generator: parameter out of range");
   end

   // ---------------------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------------------
   logic x_s1, x_s2, x_s3, v_s1, v_s2, v_s3;
   logic xtal_rise, vco_edge, vco_rise, loop_en;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         x_s1 <= 1'b0;
         x_s2 <= 1'b0;
         x_s3 <= 1'b0;
         v_s1 <= 1'b0;
         v_s2 <= 1'b0;
         v_s3 <= 1'b0;
      end else begin
         x_s1 <= xtal_pin_i;
         x_s2 <= x_s1;
         x_s3 <= x_s2;
         v_s1 <= vco_pin_i;
         v_s2 <= v_s1;
         v_s3 <= v_s2;
      end
   end

   assign xtal_rise = x_s2 & ~x_s3 & oscillator_enable_in_i;
   assign vco_edge = v_s2 & ~v_s3;
   assign vco_rise = vco_edge & loop_en;

   // ---------------------------------------------------------------------------
   // register file and wishbone slave
   // ---------------------------------------------------------------------------
   logic loop_on, base_sel, irq_en, auto_bw, trk_sw, det_trk, det_lock, settled;
   logic [P_W-1:0] pre_p;
   logic [E_W-1:0] rng_e;
   logic [N_W-1:0] ndiv;
   logic [L_W-1:0] lin;
   logic [R_W-1:0] rdiv;
   logic next_loop_on, next_base_sel, next_irq_en, next_auto, next_trk_sw, next_ack;
   logic [P_W-1:0] next_p;
   logic [E_W-1:0] next_e;
   logic [N_W-1:0] next_ndiv;
   logic [L_W-1:0] next_lin;
   logic [R_W-1:0] next_rdiv;
   logic [31:0] next_rdata, ctrl_rd, bw_rd, m;
   logic req, wr, trk_eff;

   function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                         input logic [3:0] sel);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[8*i +: 8] = new_v[8*i +: 8];
         end
      end
      return r;
   endfunction

   assign trk_eff = auto_bw ? det_trk : trk_sw;

   always_comb begin
      ctrl_rd = 32'h0;
      ctrl_rd[clock_gen_pkg::CTRL_PWR_BIT] = loop_on;
      ctrl_rd[clock_gen_pkg::CTRL_SEL_BIT] = base_sel;
      ctrl_rd[clock_gen_pkg::CTRL_IE_BIT] = irq_en;
      ctrl_rd[clock_gen_pkg::CTRL_P_LSB +: P_W] = pre_p;
      ctrl_rd[clock_gen_pkg::CTRL_E_LSB +: E_W] = rng_e;
      bw_rd = 32'h0;
      bw_rd[clock_gen_pkg::BW_AUTO_BIT] = auto_bw;
      bw_rd[clock_gen_pkg::BW_TRK_BIT] = filter_tracking_o;
      bw_rd[clock_gen_pkg::BW_SETTLED_BIT] = settled;
      req = wb_cyc_i & wb_stb_i;
      next_ack = req & ~wb_ack_o;
      // a write lands on the edge at which the master samples ack
      wr = req & wb_we_i & wb_ack_o;
      next_rdata = 32'h0;
      if (next_ack && !wb_we_i) begin
         unique case (wb_adr_i)
            clock_gen_pkg::CTRL_OFS: next_rdata = ctrl_rd;
            clock_gen_pkg::BW_OFS: next_rdata = bw_rd;
            clock_gen_pkg::NDIV_OFS: next_rdata = 32'(ndiv);
            clock_gen_pkg::LIN_OFS: next_rdata = 32'(lin);
            clock_gen_pkg::RDIV_OFS: next_rdata = 32'(rdiv);
            default: next_rdata = 32'h0;
         endcase
      end
      next_loop_on = loop_on;
      next_base_sel = base_sel;
      next_irq_en = irq_en;
      next_p = pre_p;
      next_e = rng_e;
      next_auto = auto_bw;
      next_trk_sw = trk_sw;
      next_ndiv = ndiv;
      next_lin = lin;
      next_rdiv = rdiv;
      m = 32'h0;
      if (wr) begin
         unique case (wb_adr_i)
            clock_gen_pkg::CTRL_OFS: begin
               m = merge(ctrl_rd, wb_dat_i, wb_sel_i);
               next_base_sel = m[clock_gen_pkg::CTRL_SEL_BIT] & loop_on;
               // a write that selects the vco must not also drop its power
               next_loop_on = m[clock_gen_pkg::CTRL_PWR_BIT] | base_sel | next_base_sel;
               next_irq_en = m[clock_gen_pkg::CTRL_IE_BIT];
               next_p = m[clock_gen_pkg::CTRL_P_LSB +: P_W];
               next_e = m[clock_gen_pkg::CTRL_E_LSB +: E_W];
            end
            clock_gen_pkg::BW_OFS: begin
               m = merge(bw_rd, wb_dat_i, wb_sel_i);
               next_auto = m[clock_gen_pkg::BW_AUTO_BIT];
               if (!auto_bw) begin
                  next_trk_sw = m[clock_gen_pkg::BW_TRK_BIT];
               end
            end
            clock_gen_pkg::NDIV_OFS: next_ndiv = N_W'(merge(32'(ndiv), wb_dat_i, wb_sel_i));
            clock_gen_pkg::LIN_OFS: next_lin = L_W'(merge(32'(lin), wb_dat_i, wb_sel_i));
            clock_gen_pkg::RDIV_OFS: next_rdiv = R_W'(merge(32'(rdiv), wb_dat_i, wb_sel_i));
            default: m = 32'h0;
         endcase
      end
      if (next_lin == '0) begin
         next_base_sel = 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         loop_on <= 1'b0;
         base_sel <= 1'b0;
         irq_en <= 1'b0;
         pre_p <= clock_gen_pkg::P_RST;
         rng_e <= clock_gen_pkg::E_RST;
         auto_bw <= clock_gen_pkg::AUTO_RST;
         trk_sw <= 1'b0;
         ndiv <= N_W'(clock_gen_pkg::NDIV_RST);
         lin <= L_W'(clock_gen_pkg::LIN_RST);
         rdiv <= R_W'(clock_gen_pkg::RDIV_RST);
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end else begin
         loop_on <= next_loop_on;
         base_sel <= next_base_sel;
         irq_en <= next_irq_en;
         pre_p <= next_p;
         rng_e <= next_e;
         auto_bw <= next_auto;
         trk_sw <= next_trk_sw;
         ndiv <= next_ndiv;
         lin <= next_lin;
         rdiv <= next_rdiv;
         wb_ack_o <= next_ack;
         wb_dat_o <= next_rdata;
      end
   end

   // ---------------------------------------------------------------------------
   // dividers and phase detector
   // ---------------------------------------------------------------------------
   div_if #(.W(R_W)) ref_bus ();
   div_if #(.W(N_W)) fb_bus ();
   logic [2:0] pre_cnt, next_pre_cnt, pre_mask;
   logic pre_tick, next_up, next_dn;
   logic [31:0] next_centre;

   assign loop_en = loop_on & (lin != '0);
   assign pre_mask = 3'(4'(4'h1 << pre_p) - 4'h1);
   assign pre_tick = vco_rise & ((pre_cnt & pre_mask) == pre_mask);
   assign ref_bus.factor = rdiv;
   assign ref_bus.edge_in = xtal_rise;
   assign fb_bus.factor = ndiv;
   assign fb_bus.edge_in = pre_tick;

   modulo_divider #(.W(R_W)) u_ref_div (.clk_i(clk_i), .rst_i(rst_i), .d(ref_bus));
   modulo_divider #(.W(N_W)) u_fb_div (.clk_i(clk_i), .rst_i(rst_i), .d(fb_bus));

   always_comb begin
      next_pre_cnt = vco_rise ? pre_cnt + 3'h1 : pre_cnt;
      // up leads when reference arrives first; both seen ends the pulse
      next_up = loop_en & (phase_up_o | ref_bus.tick);
      next_dn = loop_en & (phase_down_o | fb_bus.tick);
      if (next_up && next_dn) begin
         next_up = 1'b0;
         next_dn = 1'b0;
      end
      next_centre = (clock_gen_pkg::F_NOM_HZ * 32'(lin)) << rng_e;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pre_cnt <= 3'h0;
         phase_up_o <= 1'b0;
         phase_down_o <= 1'b0;
         vco_centre_hz_o <= 32'h0;
         osc_run_o <= 1'b0;
         crystal_clock_o <= 1'b0;
         loop_reference_clock_o <= 1'b0;
         divided_reference_clock_o <= 1'b0;
         vco_feedback_clock_o <= 1'b0;
         loop_enable_o <= 1'b0;
      end else begin
         pre_cnt <= next_pre_cnt;
         phase_up_o <= next_up;
         phase_down_o <= next_dn;
         vco_centre_hz_o <= next_centre;
         osc_run_o <= oscillator_enable_in_i;
         crystal_clock_o <= x_s2 & oscillator_enable_in_i;
         loop_reference_clock_o <= x_s2 & oscillator_enable_in_i;
         divided_reference_clock_o <= ref_bus.clk_out;
         vco_feedback_clock_o <= fb_bus.clk_out;
         loop_enable_o <= loop_en;
      end
   end

   // ---------------------------------------------------------------------------
   // lock detector, filter mode and settle request
   // ---------------------------------------------------------------------------
   logic [15:0] ref_per, fb_per, fb_last, diff;
   logic [15:0] next_ref_per, next_fb_per, next_fb_last;
   logic next_det_trk, next_det_lock, next_settled, next_irq;

   always_comb begin
      next_ref_per = (ref_per == 16'hffff) ? ref_per : ref_per + 16'h0001;
      next_fb_per = (fb_per == 16'hffff) ? fb_per : fb_per + 16'h0001;
      next_fb_last = fb_last;
      next_det_trk = det_trk;
      next_det_lock = det_lock;
      diff = (ref_per > fb_last) ? ref_per - fb_last : fb_last - ref_per;
      if (fb_bus.tick) begin
         next_fb_last = fb_per;
         next_fb_per = 16'h0;
      end
      // judged once per divided reference period: slow reference, slow lock
      if (ref_bus.tick) begin
         next_ref_per = 16'h0;
         next_det_trk = det_trk ? (diff <= UNT_TOL) : (diff <= TRK_TOL);
         next_det_lock = det_lock ? (diff <= UNL_TOL) : (diff <= LOCK_TOL);
      end
      if (!loop_en) begin
         next_det_trk = 1'b0;
         next_det_lock = 1'b0;
      end
      next_settled = next_auto & next_det_lock;
      next_irq = next_auto & next_irq_en & (next_settled != settled);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ref_per <= 16'h0;
         fb_per <= 16'h0;
         fb_last <= 16'h0;
         det_trk <= 1'b0;
         det_lock <= 1'b0;
         settled <= 1'b0;
         settle_irq_o <= 1'b0;
         filter_tracking_o <= 1'b0;
      end else begin
         ref_per <= next_ref_per;
         fb_per <= next_fb_per;
         fb_last <= next_fb_last;
         det_trk <= next_det_trk;
         det_lock <= next_det_lock;
         settled <= next_settled;
         settle_irq_o <= next_irq;
         filter_tracking_o <= trk_eff;
      end
   end

   // ---------------------------------------------------------------------------
   // base clock selector
   // ---------------------------------------------------------------------------
   clock_gen_pkg::src_state_t state, next_state;
   logic active_vco, next_active, next_base, xe_done, ve_done;
   logic [1:0] xe_cnt, ve_cnt, next_xe, next_ve;

   // a source known to be stopped cannot deliver its edges, so it is not awaited
   assign xe_done = (xe_cnt == clock_gen_pkg::SETTLE_EDGES) | ~oscillator_enable_in_i;
   assign ve_done = (ve_cnt == clock_gen_pkg::SETTLE_EDGES) | ~loop_en;

   always_comb begin
      next_state = state;
      next_active = active_vco;
      next_xe = xe_cnt;
      next_ve = ve_cnt;
      next_base = base_clock_out_o;
      unique case (state)
         clock_gen_pkg::SRC_RUN: begin
            if (base_sel != active_vco) begin
               next_state = clock_gen_pkg::SRC_HOLD;
               next_xe = 2'h0;
               next_ve = 2'h0;
            end else if (active_vco ? vco_rise : xtal_rise) begin
               next_base = ~base_clock_out_o;
            end
         end
         clock_gen_pkg::SRC_HOLD: begin
            if (xtal_rise && !xe_done) begin
               next_xe = xe_cnt + 2'h1;
            end
            if (vco_edge && !ve_done) begin
               next_ve = ve_cnt + 2'h1;
            end
            if (xe_done && ve_done) begin
               next_active = base_sel;
               next_state = clock_gen_pkg::SRC_RUN;
            end
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= clock_gen_pkg::SRC_RUN;
         active_vco <= 1'b0;
         xe_cnt <= 2'h0;
         ve_cnt <= 2'h0;
         base_clock_out_o <= 1'b0;
      end else begin
         state <= next_state;
         active_vco <= next_active;
         xe_cnt <= next_xe;
         ve_cnt <= next_ve;
         base_clock_out_o <= next_base;
      end
   end

   // ---------------------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   osc_gated_a: assert property (!$past(oscillator_enable_in_i) |-> !crystal_clock_o)
      else $error("crystal clock runs without enable");
   ref_copy_a: assert property (loop_reference_clock_o == crystal_clock_o)
      else $error("reference clock differs from crystal clock");
   pfd_excl_a: assert property (!(phase_up_o && phase_down_o))
      else $error("phase up and down together");
   hold_static_a: assert property (state == clock_gen_pkg::SRC_HOLD && $past(state) == clock_gen_pkg::SRC_HOLD
      |-> $stable(base_clock_out_o))
      else $error("base clock moved during hold");
   sel_needs_power_a: assert property ($rose(base_sel) |-> $past(loop_on) && loop_on)
      else $error("vco selected with loop off");
   no_power_off_a: assert property ($past(base_sel) |-> loop_on)
      else $error("loop powered off while vco selected");
   lin_zero_a: assert property (lin == '0 |-> !base_sel ##1 !loop_enable_o)
      else $error("zero linear factor left loop usable");
   manual_quiet_a: assert property (!auto_bw && $past(!auto_bw) |-> !settled && !settle_irq_o)
      else $error("manual mode shows settle activity");
   irq_toggle_a: assert property (settle_irq_o |-> settled != $past(settled) && irq_en)
      else $error("settle request without toggle");
   trk_follow_a: assert property (auto_bw && $past(auto_bw) |-> filter_tracking_o == $past(det_trk))
      else $error("tracking select not following detector");

   switch_vco_c: cover property ($rose(active_vco));
   settle_irq_c: cover property (settle_irq_o);
   hold_c: cover property (state == clock_gen_pkg::SRC_HOLD ##1 state == clock_gen_pkg::SRC_RUN);
endmodule

// ===== test/pin_source.sv
// pin clock sources standing in for the crystal pad and the vco
module pin_source (
   input wire logic vco_run_i,
   output logic xtal_o,
   output logic vco_o
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      xtal_o = 1'b0;
      vco_o = 1'b0;
   end
   always #40 xtal_o = ~xtal_o;
   // same rate as the crystal but unrelated phase; halts low while the loop is off
   initial begin
      #13;
      forever #40 vco_o = vco_run_i ? ~vco_o : 1'b0;
   end
endmodule

// ===== test/testbench.sv
// self-checking bench of the clock generator control
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, osc_en = 1'b0;
   logic [4:0] adr = 5'h00;
   logic [31:0] dat = 32'h0, wb_dat_o, rd;
   logic wb_ack_o, osc_run_o, crystal_clock_o, loop_reference_clock_o, divided_reference_clock_o;
   logic vco_feedback_clock_o, base_clock_out_o, loop_enable_o, filter_tracking_o, settle_irq_o;
   logic xtal, vco, up, dn;
   logic [31:0] vco_centre_hz_o;
   logic [3:0] prv, cur;
   int cnt[4];
   int irqs = 0, ups = 0, downs = 0, miscompares = 0, tests_run = 0;
   always #4 clk_i = ~clk_i;
   clock_generator dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .oscillator_enable_in_i(osc_en), .xtal_pin_i(xtal), .vco_pin_i(vco), .osc_run_o(osc_run_o),
      .crystal_clock_o(crystal_clock_o), .loop_reference_clock_o(loop_reference_clock_o),
      .divided_reference_clock_o(divided_reference_clock_o), .vco_feedback_clock_o(vco_feedback_clock_o),
      .base_clock_out_o(base_clock_out_o), .loop_enable_o(loop_enable_o),
      .filter_tracking_o(filter_tracking_o), .phase_up_o(up), .phase_down_o(dn),
      .vco_centre_hz_o(vco_centre_hz_o), .settle_irq_o(settle_irq_o));
   pin_source partner (.vco_run_i(loop_enable_o), .xtal_o(xtal), .vco_o(vco));
   assign cur = {crystal_clock_o, vco_feedback_clock_o, divided_reference_clock_o, base_clock_out_o};
   always @(posedge clk_i) begin
      prv <= cur;
      for (int i = 0; i < 4; i++) if (prv[i] !== cur[i]) cnt[i]++;
      if (settle_irq_o === 1'b1) irqs++;
      if (up === 1'b1) ups++;
      if (dn === 1'b1) downs++;
   end
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      rd = wb_dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (n >= 50) chk("ack", 32'h0, 32'h1);
   endtask
   task automatic rdchk(input string nm, input logic [4:0] a, input logic [31:0] exp);
      wb(1'b0, a, 32'h0);
      chk(nm, rd, exp);
   endtask
   // clears the toggle counters, then lets the given span pass
   task automatic measure(input int ns);
      @(posedge clk_i);
      #1;
      foreach (cnt[i]) cnt[i] = 0;
      #(ns);
      // back on an edge so that the next stimulus lands on the clock
      @(posedge clk_i);
   endtask
   function automatic logic [31:0] near(input int c, input int e);
      return {31'h0, (c >= e - 1 && c <= e + 1)};
   endfunction
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      #200us;
      miscompares++;
      print_verdict();
   end
   initial begin
      logic [4:0] ofs[6] = '{5'h00, 5'h04, 5'h08, 5'h0c, 5'h10, 5'h14};
      logic [31:0] rv[6] = '{32'h0, 32'h1, 32'h1, 32'h0, 32'h1, 32'h0};
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      foreach (ofs[i]) rdchk("reset value", ofs[i], rv[i]);
      wb(1'b1, 5'h14, 32'hffff_ffff);
      rdchk("unmapped", 5'h14, 32'h0);
      $display("test registers done");
      // ---------------------------------------------------------------
      // crystal gating and base clock from the crystal
      // ---------------------------------------------------------------
      measure(800);
      chk("osc off", cnt[3], 32'h0);
      chk("osc run", {31'h0, osc_run_o}, 32'h0);
      osc_en <= 1'b1;
      measure(800);
      chk("crystal", near(cnt[3], 20), 32'h1);
      chk("reference", {31'h0, loop_reference_clock_o}, {31'h0, crystal_clock_o});
      chk("base xtal", near(cnt[0], 10), 32'h1);
      chk("osc on", {31'h0, osc_run_o}, 32'h1);
      $display("test crystal done");
      // ---------------------------------------------------------------
      // refusals and centre frequency
      // ---------------------------------------------------------------
      wb(1'b1, 5'h00, 32'h2);
      rdchk("sel while off", 5'h00, 32'h0);
      wb(1'b1, 5'h00, 32'h3);
      // loop now powered: only the zero linear factor can refuse the vco
      wb(1'b1, 5'h00, 32'h3);
      rdchk("sel with l zero", 5'h00, 32'h1);
      chk("loop l zero", {31'h0, loop_enable_o}, 32'h0);
      wb(1'b1, 5'h0c, 32'h0a);
      wb(1'b1, 5'h00, 32'h105);
      repeat (3) @(posedge clk_i);
      chk("loop on", {31'h0, loop_enable_o}, 32'h1);
      chk("centre", vco_centre_hz_o, 32'h000b_b800);
      $display("test refusals done");
      // ---------------------------------------------------------------
      // self-control lock, then vco as base source
      // ---------------------------------------------------------------
      repeat (600) @(posedge clk_i);
      rdchk("bw locked", 5'h04, 32'h7);
      chk("irq seen", {31'h0, irqs > 0}, 32'h1);
      chk("tracking", {31'h0, filter_tracking_o}, 32'h1);
      wb(1'b1, 5'h00, 32'h107);
      rdchk("sel vco", 5'h00, 32'h107);
      wb(1'b1, 5'h00, 32'h106);
      rdchk("off refused", 5'h00, 32'h107);
      // crystal stopped, so only the vco can move the base clock
      osc_en <= 1'b0;
      repeat (40) @(posedge clk_i);
      measure(800);
      chk("base vco", near(cnt[0], 10), 32'h1);
      chk("osc gated", cnt[3], 32'h0);
      osc_en <= 1'b1;
      wb(1'b1, 5'h00, 32'h105);
      $display("test lock done");
      // ---------------------------------------------------------------
      // loop dividers
      // ---------------------------------------------------------------
      wb(1'b1, 5'h10, 32'h2);
      measure(1600);
      chk("ref div", near(cnt[1], 20), 32'h1);
      wb(1'b1, 5'h08, 32'h3);
      wb(1'b1, 5'h00, 32'h115);
      measure(4800);
      chk("fb div", near(cnt[2], 20), 32'h1);
      chk("phase both", {31'h0, ups > 0 && downs > 0}, 32'h1);
      $display("test dividers done");
      // ---------------------------------------------------------------
      // manual bandwidth mode
      // ---------------------------------------------------------------
      irqs = 0;
      wb(1'b1, 5'h04, 32'h0);
      rdchk("manual acq", 5'h04, 32'h0);
      chk("acq mode", {31'h0, filter_tracking_o}, 32'h0);
      wb(1'b1, 5'h00, 32'h114);
      wb(1'b1, 5'h00, 32'h115);
      repeat (100) @(posedge clk_i);
      wb(1'b1, 5'h04, 32'h2);
      rdchk("manual trk", 5'h04, 32'h2);
      chk("trk mode", {31'h0, filter_tracking_o}, 32'h1);
      repeat (200) @(posedge clk_i);
      wb(1'b1, 5'h00, 32'h117);
      rdchk("manual vco", 5'h00, 32'h117);
      chk("no irq", irqs, 32'h0);
      $display("test manual done");
      print_verdict();
   end
endmodule
